// >>> rtl/cshi_top.sv
`timescale 1ns/1ps
// Overview of operation
// - status bit 7 shows bus off
// - status bit 6 shows controller error
// - bits 5,4 show transmit, receive activity
// - bit 3 set when last transmit done
// - bit 2 shows transmit buffer free
// - bit 1 shows receive overrun
// - bit 0 shows frames waiting
// - overflow bit 1 command buffer overflow
// - overflow bit 0 receive buffer overflow
// - reset command clears error, overflow flags
// - reset restarts controller, recovers bus off
// - commands before init return code 28
// - bit timing bytes for 16 MHz
// - format flag: 0 standard, 1 extended
// - identifier masked to 29 bits for both frame formats
// - remote request flag per frame
// - payload length capped at eight bytes
// - fetch errors while buffer full flagged
// - codes 22 empty, 23 full
// - code 21 timeout, 0 success
// - overflow value 2 tx, 1 rx, 3 both
module cshi_top
    import cshi_pkg::*;
#(
    parameter int RX_DEPTH = 4,
    parameter int TIMEOUT = TIMEOUT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CTRL_BUS_OFF,
    input wire logic CTRL_ERROR,
    input wire logic CTRL_TX_BUSY,
    input wire logic CTRL_RX_BUSY,
    input wire logic CTRL_TX_DONE,
    input wire logic CTRL_RX_VALID,
    input wire logic [28:0] CTRL_RX_ID,
    input wire logic [5:0] CTRL_RX_CTRL,
    input wire logic [63:0] CTRL_RX_DATA,
    output logic CTRL_RESTART,
    output logic CTRL_TX_START,
    output logic [28:0] CTRL_TX_ID,
    output logic [5:0] CTRL_TX_CTRL,
    output logic [63:0] CTRL_TX_DATA,
    output logic [31:0] CTRL_BIT_RATE,
    output logic [15:0] CTRL_TIMING,
    output logic [31:0] CTRL_ACC_CODE,
    output logic [31:0] CTRL_ACC_MASK
);
    // elaboration checks on values the logic cannot serve
    if (RX_DEPTH < 2 || RX_DEPTH > 16) begin : g_bad_depth
        $error("rx depth out of range");
    end
    if (TIMEOUT < 1) begin : g_bad_timeout
        $error("timeout must be positive");
    end

    localparam int PW = $clog2(RX_DEPTH);
    localparam int AW = PW + 1;
    localparam logic [AW-1:0] DEPTH_W = AW'(RX_DEPTH);

    logic rst_s1, rst_sync; // reset release synchroniser
    logic [7:0] sts_sync1, sts_sync2, sts_sync3, sts_live; // pin filter stages
    logic initialised; // set by init command
    logic [7:0] result; // last command result
    logic ov_rx, ov_cmd; // sticky overflow flags
    logic err_latched; // controller error held until reset
    logic tx_locked, tx_done; // transmit buffer state
    logic [31:0] timer; // response time limit counter
    logic done_seen; // done level at the previous edge
    logic done_rise; // controller finished a frame this cycle
    logic tx_timeout; // locked frame ran out of time
    logic [28:0] rx_id_mem [RX_DEPTH]; // received frame store
    logic [5:0] rx_ctl_mem [RX_DEPTH];
    logic [63:0] rx_dat_mem [RX_DEPTH];
    logic [PW-1:0] rd_ptr, wr_ptr;
    logic [AW-1:0] count;
    logic [28:0] out_id; // fetched frame
    logic [5:0] out_ctl;
    logic [63:0] out_dat;
    logic [7:0] status;
    logic wr, rd, cmd_wr;
    cshi_cmd_t cmd;
    logic rx_push, rx_pop;

    // async assert, synchronous release
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1 <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync <= rst_s1;
        end
    end

    // controller status pins pass three stages; change once stages two and three agree
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            sts_sync1 <= 8'h00;
            sts_sync2 <= 8'h00;
            sts_sync3 <= 8'h00;
            sts_live <= 8'h00;
        end else begin
            sts_sync1 <= {CTRL_BUS_OFF, CTRL_ERROR, CTRL_TX_BUSY, CTRL_RX_BUSY,
                          CTRL_TX_DONE, 3'b000};
            sts_sync2 <= sts_sync1;
            sts_sync3 <= sts_sync2;
            for (int i = 0; i < 8; i++) begin
                if (sts_sync2[i] == sts_sync3[i]) sts_live[i] <= sts_sync3[i];
            end
        end
    end

    // apb decode; zero wait states
    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && PENABLE && !PWRITE;
    assign cmd_wr = wr && (PADDR == OFS_COMMAND);
    assign cmd = cshi_cmd_t'(PWDATA[2:0]);
    assign PREADY = 1'b1;
    assign rx_push = CTRL_RX_VALID && (count != DEPTH_W);
    assign rx_pop = cmd_wr && (cmd == CMD_FETCH) && initialised && (count != '0) && !ov_rx;
    // done stays up after a frame, so only its rise ends a new one
    assign done_rise = sts_live[ST_TX_DONE] && !done_seen;
    // no time limit report when a reset command drops the frame
    assign tx_timeout = tx_locked && !done_rise && (timer == 32'(TIMEOUT - 1))
        && !(cmd_wr && cmd == CMD_RESET);

    // previous done level; resets low like the idle pin, so no false rise
    // limitation: a frame too short for the low to pass the filter ends by time limit
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) done_seen <= 1'b0;
        else done_seen <= sts_live[ST_TX_DONE];
    end

    // assemble the live status byte; reads never touch state
    always_comb begin
        status = 8'h00;
        status[ST_BUS_OFF] = sts_live[ST_BUS_OFF];
        status[ST_ERROR] = err_latched || sts_live[ST_ERROR];
        status[ST_TX_BUSY] = sts_live[ST_TX_BUSY];
        status[ST_RX_BUSY] = sts_live[ST_RX_BUSY];
        status[ST_TX_DONE] = tx_done;
        status[ST_TX_FREE] = !tx_locked;
        status[ST_OVERRUN] = ov_rx;
        status[ST_RX_AVAIL] = (count != '0);
    end

    // initialisation state and configuration registers
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            initialised <= 1'b0;
            CTRL_BIT_RATE <= 32'h00000000;
            CTRL_TIMING <= 16'h0000;
            CTRL_ACC_CODE <= 32'h00000000;
            CTRL_ACC_MASK <= 32'hFFFFFFFF;
        end else begin
            if (wr && PADDR == OFS_BIT_RATE) CTRL_BIT_RATE <= PWDATA;
            if (wr && PADDR == OFS_TIMING) CTRL_TIMING <= PWDATA[15:0];
            if (wr && PADDR == OFS_ACC_CODE) CTRL_ACC_CODE <= PWDATA;
            if (wr && PADDR == OFS_ACC_MASK) CTRL_ACC_MASK <= PWDATA;
            if (cmd_wr && cmd == CMD_INIT) initialised <= 1'b1;
        end
    end

    // transmit frame staging; length capped, id masked to 29 bits for both formats
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            CTRL_TX_ID <= 29'h00000000;
            CTRL_TX_CTRL <= 6'h00;
            CTRL_TX_DATA <= 64'h0000000000000000;
        end else if (!tx_locked) begin
            if (wr && PADDR == OFS_TX_ID) begin
                CTRL_TX_ID <= PWDATA[28:0] & ID_MAX_EXT;
            end
            if (wr && PADDR == OFS_TX_CTRL) begin
                CTRL_TX_CTRL[CTL_FMT] <= PWDATA[CTL_FMT];
                CTRL_TX_CTRL[CTL_RTR] <= PWDATA[CTL_RTR];
                CTRL_TX_CTRL[3:0] <= (PWDATA[3:0] > MAX_LEN) ? MAX_LEN : PWDATA[3:0];
            end
            if (wr && PADDR == OFS_TX_DATA_LO) CTRL_TX_DATA[31:0] <= PWDATA;
            if (wr && PADDR == OFS_TX_DATA_HI) CTRL_TX_DATA[63:32] <= PWDATA;
        end
    end

    // transmit lock, completion and time limit
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            tx_locked <= 1'b0;
            tx_done <= 1'b0;
            timer <= 32'h00000000;
            CTRL_TX_START <= 1'b0;
        end else begin
            CTRL_TX_START <= 1'b0;
            if (cmd_wr && cmd == CMD_RESET) begin
                tx_locked <= 1'b0;
                tx_done <= 1'b0;
                timer <= 32'h00000000;
            end else if (cmd_wr && cmd == CMD_QUEUE && initialised && !tx_locked) begin
                tx_locked <= 1'b1;
                tx_done <= 1'b0;
                timer <= 32'h00000000;
                CTRL_TX_START <= 1'b1;
            end else if (tx_locked) begin
                if (done_rise) begin
                    tx_locked <= 1'b0;
                    tx_done <= 1'b1;
                end else if (tx_timeout) begin
                    tx_locked <= 1'b0;
                end else begin
                    timer <= timer + 32'h00000001;
                end
            end
        end
    end

    // received frame store; oldest frame presented for fetch
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else if (cmd_wr && cmd == CMD_RESET) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else begin
            if (rx_push) wr_ptr <= (wr_ptr == PW'(RX_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (rx_pop) rd_ptr <= (rd_ptr == PW'(RX_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (rx_push && !rx_pop) count <= count + 1'b1;
            else if (rx_pop && !rx_push) count <= count - 1'b1;
        end
    end

    // frame memory write, no reset needed
    always_ff @(posedge SYS_CLK) begin
        if (rx_push) begin
            rx_id_mem[wr_ptr] <= CTRL_RX_ID;
            rx_ctl_mem[wr_ptr] <= CTRL_RX_CTRL;
            rx_dat_mem[wr_ptr] <= CTRL_RX_DATA;
        end
    end

    // fetched frame registers
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            out_id <= 29'h00000000;
            out_ctl <= 6'h00;
            out_dat <= 64'h0000000000000000;
        end else if (rx_pop) begin
            out_id <= rx_id_mem[rd_ptr];
            out_ctl <= rx_ctl_mem[rd_ptr];
            out_dat <= rx_dat_mem[rd_ptr];
        end
    end

    // sticky flags; set beats clear in the same cycle
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            ov_rx <= 1'b0;
            ov_cmd <= 1'b0;
            err_latched <= 1'b0;
        end else begin
            if (cmd_wr && (cmd == CMD_RESET || cmd == CMD_CLEAR)) begin
                ov_rx <= 1'b0;
                ov_cmd <= 1'b0;
            end
            if (cmd_wr && cmd == CMD_RESET) err_latched <= 1'b0;
            if (CTRL_RX_VALID && count == DEPTH_W) ov_rx <= 1'b1;
            if (cmd_wr && cmd == CMD_QUEUE && tx_locked && initialised) ov_cmd <= 1'b1;
            if (sts_live[ST_ERROR]) err_latched <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) CTRL_RESTART <= 1'b0;
        else CTRL_RESTART <= cmd_wr && (cmd == CMD_RESET);
    end

    // command result code
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            result <= RES_SUCCESS;
        end else if (tx_timeout) begin
            result <= RES_NO_RESPONSE;
        end else if (cmd_wr) begin
            if (!initialised && cmd != CMD_INIT) begin
                result <= RES_UNINIT;
            end else if (cmd == CMD_FETCH) begin
                if (ov_rx) result <= RES_BUF_FULL;
                else if (count == '0) result <= RES_BUF_EMPTY;
                else result <= RES_SUCCESS;
            end else if (cmd == CMD_QUEUE && tx_locked) begin
                result <= RES_BUF_FULL;
            end else begin
                result <= RES_SUCCESS;
            end
        end
    end

    // apb read mux; registered data, unmapped reads zero, with error only above OFS_RX_DATA_HI
    always_ff @(posedge SYS_CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                OFS_STATUS: PRDATA <= {24'h000000, status};
                // value 2 tx, 1 rx, 3 both
                OFS_OVERFLOW: PRDATA <= {30'h00000000, ov_cmd, ov_rx};
                OFS_RESULT: PRDATA <= {24'h000000, result};
                OFS_BIT_RATE: PRDATA <= CTRL_BIT_RATE;
                OFS_TIMING: PRDATA <= {16'h0000, CTRL_TIMING};
                OFS_ACC_CODE: PRDATA <= CTRL_ACC_CODE;
                OFS_ACC_MASK: PRDATA <= CTRL_ACC_MASK;
                OFS_RX_ID: PRDATA <= {3'b000, out_id};
                OFS_RX_CTRL: PRDATA <= {26'h0000000, out_ctl};
                OFS_RX_DATA_LO: PRDATA <= out_dat[31:0];
                OFS_RX_DATA_HI: PRDATA <= out_dat[63:32];
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

    // address above OFS_RX_DATA_HI gives slave error in access phase
    always_comb begin
        PSLVERR = 1'b0;
        if (PSEL && PENABLE && PADDR > OFS_RX_DATA_HI) PSLVERR = 1'b1;
    end

    property p_rx_avail;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        status[ST_RX_AVAIL] == (count != '0);
    endproperty
    a_rx_avail: assert property (p_rx_avail) else $error("avail bit wrong");

    property p_uninit;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        (cmd_wr && !initialised && cmd != CMD_INIT) |=> result == RES_UNINIT;
    endproperty
    a_uninit: assert property (p_uninit) else $error("uninit code missing");

    property p_ov_rx;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        (CTRL_RX_VALID && count == DEPTH_W) |=> ov_rx && status[ST_OVERRUN];
    endproperty
    a_ov_rx: assert property (p_ov_rx) else $error("rx overflow not set");

    property p_reset_clear;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        (cmd_wr && cmd == CMD_RESET && !CTRL_RX_VALID && !sts_live[ST_ERROR])
            |=> !ov_rx && !ov_cmd && !err_latched && CTRL_RESTART;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left flags");

    property p_len_cap;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        CTRL_TX_CTRL[3:0] <= MAX_LEN;
    endproperty
    a_len_cap: assert property (p_len_cap) else $error("length above eight");

    property p_tx_free;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        $rose(CTRL_TX_START) |-> !status[ST_TX_FREE] && !status[ST_TX_DONE];
    endproperty
    a_tx_free: assert property (p_tx_free) else $error("tx buffer not locked");

    property p_tx_done;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        (tx_locked && done_rise && !cmd_wr) |=> status[ST_TX_DONE];
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("done not shown");

    property p_timeout;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        tx_timeout |=> result == RES_NO_RESPONSE && status[ST_TX_FREE];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout code missing");

    property p_empty;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        (cmd_wr && cmd == CMD_FETCH && initialised && !ov_rx && count == '0)
            |=> result == RES_BUF_EMPTY;
    endproperty
    a_empty: assert property (p_empty) else $error("empty code missing");

    property p_bus_off;
        @(posedge SYS_CLK) disable iff (!rst_sync)
        $past(sts_sync3[ST_BUS_OFF]) == $past(sts_sync2[ST_BUS_OFF])
            |-> status[ST_BUS_OFF] == $past(sts_sync3[ST_BUS_OFF]);
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus off bit wrong");
endmodule

// >>> rtl/cshi_pkg.sv
package cshi_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_OVERFLOW = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_BIT_RATE = 8'h10;
    localparam logic [7:0] OFS_TIMING = 8'h14;
    localparam logic [7:0] OFS_ACC_CODE = 8'h18;
    localparam logic [7:0] OFS_ACC_MASK = 8'h1C;
    localparam logic [7:0] OFS_TX_ID = 8'h20;
    localparam logic [7:0] OFS_TX_CTRL = 8'h24;
    localparam logic [7:0] OFS_TX_DATA_LO = 8'h28;
    localparam logic [7:0] OFS_TX_DATA_HI = 8'h2C;
    localparam logic [7:0] OFS_RX_ID = 8'h30;
    localparam logic [7:0] OFS_RX_CTRL = 8'h34;
    localparam logic [7:0] OFS_RX_DATA_LO = 8'h38;
    localparam logic [7:0] OFS_RX_DATA_HI = 8'h3C;
    // controller status bit positions
    localparam int ST_BUS_OFF = 7;
    localparam int ST_ERROR = 6;
    localparam int ST_TX_BUSY = 5;
    localparam int ST_RX_BUSY = 4;
    localparam int ST_TX_DONE = 3;
    localparam int ST_TX_FREE = 2;
    localparam int ST_OVERRUN = 1;
    localparam int ST_RX_AVAIL = 0;
    // overflow flag bit positions
    localparam int OV_RX = 0;
    localparam int OV_CMD = 1;
    // control field positions (frame control word)
    localparam int CTL_LEN_LSB = 0;
    localparam int CTL_RTR = 4;
    localparam int CTL_FMT = 5;
    // identifier limits
    localparam logic [28:0] ID_MAX_STD = 29'h000003FF;
    localparam logic [28:0] ID_MAX_EXT = 29'h1FFFFFFF;
    localparam logic [3:0] MAX_LEN = 4'h8;
    // controller clock
    localparam int CTRL_CLK_HZ = 16000000;
    // commands written to the command register
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_INIT = 3'b001,
        CMD_RESET = 3'b010,
        CMD_QUEUE = 3'b011,
        CMD_FETCH = 3'b100,
        CMD_CLEAR = 3'b101
    } cshi_cmd_t;
    // result codes
    localparam logic [7:0] RES_SUCCESS = 8'h00;
    localparam logic [7:0] RES_NO_RESPONSE = 8'h15;
    localparam logic [7:0] RES_BUF_EMPTY = 8'h16;
    localparam logic [7:0] RES_BUF_FULL = 8'h17;
    localparam logic [7:0] RES_UNINIT = 8'h1C;
    // response time limit
    localparam int TIMEOUT_US = 10;
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
endpackage

// >>> verif/cshi_ctrl_model.sv
`timescale 1ns/1ps
// behavioural can controller standing behind the host interface
module cshi_ctrl_model (
    input wire logic clk,
    input wire logic tx_start,
    input wire logic restart,
    input wire logic [15:0] tx_delay,
    output logic tx_busy,
    output logic tx_done,
    output logic rx_busy,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic [5:0] rx_ctrl,
    output logic [63:0] rx_data
);
    logic [15:0] cnt; // cycles left on the wire, zero hangs until restart

    // quiet lines at time zero
    initial begin
        tx_busy = 1'b0;
        tx_done = 1'b0;
        rx_busy = 1'b0;
        rx_valid = 1'b0;
        rx_id = 29'h00000000;
        rx_ctrl = 6'h00;
        rx_data = 64'h0000000000000000;
        cnt = 16'h0000;
    end

    always @(posedge clk) begin
        if (restart) begin
            tx_busy <= 1'b0;
            cnt <= 16'h0000;
        end else if (tx_start) begin
            tx_busy <= 1'b1;
            tx_done <= 1'b0;
            cnt <= tx_delay;
        end else if (tx_busy && cnt == 16'h0001) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
        end else if (cnt > 16'h0001) begin
            cnt <= cnt - 16'h0001;
        end
    end

    // one received frame, pulse then scrambled lines
    task automatic push(input logic [28:0] id, input logic [5:0] ctl, input logic [63:0] d);
        @(posedge clk);
        rx_busy <= 1'b1;
        repeat (4) @(posedge clk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_ctrl <= ctl;
        rx_data <= d;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_busy <= 1'b0;
        rx_id <= ~id;
        rx_ctrl <= ~ctl;
        rx_data <= ~d;
    endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import cshi_pkg::*;
;
    localparam int TMO = 64; // short limit, still above the 30-cycle test frame
    localparam int DEPTH = 4;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} cshi_row_t;
    // register rows: write, read back, expected slave error
    cshi_row_t rows [5] = '{'{OFS_BIT_RATE, 32'h0003D090, 32'h0003D090, 1'b0},
        '{OFS_TIMING, 32'h00001C03, 32'h00001C03, 1'b0},
        '{OFS_ACC_CODE, 32'h000000A0, 32'h000000A0, 1'b0},
        '{OFS_ACC_MASK, 32'h1FFFFFFF, 32'h1FFFFFFF, 1'b0},
        '{8'h40, 32'h12345678, 32'h00000000, 1'b1}};
    logic [28:0] f_id [2] = '{29'h1FFFFFFF, 29'h000003FF};
    logic [5:0] f_ctl [2] = '{6'h28, 6'h10};
    logic clk, rst_n, psel, penable, pwrite, bus_off, err_in, q_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, q, PRDATA;
    logic [15:0] tx_delay;
    logic PREADY, PSLVERR, tx_busy, tx_done, rx_busy, rx_valid, restart, tx_start;
    logic [28:0] rx_id, tx_id;
    logic [5:0] rx_ctrl, tx_ctrl;
    logic [63:0] rx_data, tx_data;
    logic [31:0] bit_rate, acc_code, acc_mask;
    logic [15:0] timing;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_start = 0;
    int n_restart = 0;

    cshi_top #(.RX_DEPTH(DEPTH), .TIMEOUT(TMO)) cshi_top_inst (.SYS_CLK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CTRL_BUS_OFF(bus_off),
        .CTRL_ERROR(err_in), .CTRL_TX_BUSY(tx_busy), .CTRL_RX_BUSY(rx_busy),
        .CTRL_TX_DONE(tx_done), .CTRL_RX_VALID(rx_valid), .CTRL_RX_ID(rx_id),
        .CTRL_RX_CTRL(rx_ctrl), .CTRL_RX_DATA(rx_data), .CTRL_RESTART(restart),
        .CTRL_TX_START(tx_start), .CTRL_TX_ID(tx_id), .CTRL_TX_CTRL(tx_ctrl),
        .CTRL_TX_DATA(tx_data), .CTRL_BIT_RATE(bit_rate), .CTRL_TIMING(timing),
        .CTRL_ACC_CODE(acc_code), .CTRL_ACC_MASK(acc_mask));
    cshi_ctrl_model cshi_ctrl_model_inst (.clk(clk), .tx_start(tx_start), .restart(restart),
        .tx_delay(tx_delay), .tx_busy(tx_busy), .tx_done(tx_done), .rx_busy(rx_busy),
        .rx_valid(rx_valid), .rx_id(rx_id), .rx_ctrl(rx_ctrl), .rx_data(rx_data));

    // free-running system clock
    always #5 clk = ~clk;
    // pulse counters for start and restart
    always @(posedge clk) begin
        if (tx_start === 1'b1) n_start++;
        if (restart === 1'b1) n_restart++;
    end

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // one apb transfer; idle cycle after so psel never toggles in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t no ready", $time);
            conclude();
        end
        q = PRDATA;
        q_err = PSLVERR;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input string s);
        apb(1'b0, a, 32'h00000000);
        chk({32'h00000000, q & m}, {32'h00000000, e}, s);
    endtask
    // command, then result one edge later
    task automatic cmd(input cshi_cmd_t c, input logic [7:0] res);
        apb(1'b1, OFS_COMMAND, {29'h00000000, c});
        @(posedge clk);
        rd(OFS_RESULT, 32'h000000FF, {24'h000000, res}, "result");
    endtask
    // bounded wait for the far side to finish a frame
    task automatic wait_done();
        int n;
        n = 0;
        while (tx_done !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n == 200) begin
            n_mismatch++;
            $display("BAD %0t tx never done", $time);
            conclude();
        end
        repeat (6) @(posedge clk);
    endtask
    task automatic queue(input logic [15:0] dly, input logic [7:0] res);
        tx_delay <= dly;
        cmd(CMD_QUEUE, res);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        bus_off = 1'b0;
        err_in = 1'b0;
        tx_delay = 16'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({32'h00000000, acc_mask}, 64'h00000000FFFFFFFF, "mask reset");
        rd(OFS_STATUS, 32'h000000C7, 32'h00000004, "status reset");
        rd(OFS_OVERFLOW, 32'h00000003, 32'h00000000, "ovf reset");
        cmd(CMD_FETCH, RES_UNINIT);
        cmd(CMD_QUEUE, RES_UNINIT);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rd(rows[i].a, 32'hFFFFFFFF, rows[i].e, "readback");
            chk({63'h0, q_err}, {63'h0, rows[i].err}, "slverr");
        end
        cmd(CMD_INIT, RES_SUCCESS);
        chk({bit_rate, 16'h0000, timing}, 64'h0003D09000001C03, "timing out");
        chk({acc_code, acc_mask}, 64'h000000A01FFFFFFF, "filter out");
        cmd(CMD_FETCH, RES_BUF_EMPTY);
        for (int i = 0; i < 2; i++) begin
            cshi_ctrl_model_inst.push(f_id[i], f_ctl[i], 64'h8877665544332211);
            repeat (6) @(posedge clk);
            rd(OFS_STATUS, 32'h00000011, 32'h00000001, "rx avail");
            cmd(CMD_FETCH, RES_SUCCESS);
            rd(OFS_RX_ID, 32'h1FFFFFFF, {3'h0, f_id[i]}, "rx id");
            rd(OFS_RX_CTRL, 32'h0000003F, {26'h0, f_ctl[i]}, "rx ctrl");
            rd(OFS_RX_DATA_HI, 32'hFFFFFFFF, 32'h88776655, "rx data");
            rd(OFS_RX_DATA_LO, 32'hFFFFFFFF, 32'h44332211, "rx data lo");
            rd(OFS_STATUS, 32'h00000001, 32'h00000000, "rx empty");
        end
        apb(1'b1, OFS_TX_ID, 32'h0ABCDEF1);
        apb(1'b1, OFS_TX_CTRL, 32'h0000002F); // length 15 asked, 8 kept
        apb(1'b1, OFS_TX_DATA_LO, 32'h04030201);
        apb(1'b1, OFS_TX_DATA_HI, 32'h08070605);
        queue(16'h001E, RES_SUCCESS);
        repeat (6) @(posedge clk);
        rd(OFS_STATUS, 32'h0000002C, 32'h00000020, "tx busy locked");
        apb(1'b1, OFS_TX_ID, 32'h00000000);
        queue(16'h001E, RES_BUF_FULL);
        rd(OFS_OVERFLOW, 32'h00000003, 32'h00000002, "cmd ovf");
        chk({35'h0, tx_id}, {35'h0, 29'h0ABCDEF1}, "tx id frozen");
        chk({58'h0, tx_ctrl}, {58'h0, 6'h28}, "tx ctrl");
        chk(tx_data, 64'h0807060504030201, "tx data");
        wait_done();
        rd(OFS_STATUS, 32'h0000002C, 32'h0000000C, "tx done free");
        repeat (DEPTH + 1) cshi_ctrl_model_inst.push(29'h00000123, 6'h01, 64'hA5);
        repeat (6) @(posedge clk);
        rd(OFS_OVERFLOW, 32'h00000003, 32'h00000003, "both ovf");
        rd(OFS_STATUS, 32'h00000002, 32'h00000002, "overrun");
        cmd(CMD_FETCH, RES_BUF_FULL);
        cmd(CMD_CLEAR, RES_SUCCESS);
        rd(OFS_OVERFLOW, 32'h00000003, 32'h00000000, "ovf cleared");
        queue(16'h0000, RES_SUCCESS);
        repeat (TMO + 10) @(posedge clk);
        rd(OFS_RESULT, 32'h000000FF, {24'h0, RES_NO_RESPONSE}, "timeout");
        rd(OFS_STATUS, 32'h00000004, 32'h00000004, "unlocked");
        bus_off <= 1'b1;
        err_in <= 1'b1;
        repeat (6) @(posedge clk);
        rd(OFS_STATUS, 32'h000000C0, 32'h000000C0, "bus off");
        rd(OFS_STATUS, 32'h000000C0, 32'h000000C0, "live again");
        bus_off <= 1'b0;
        err_in <= 1'b0;
        repeat (6) @(posedge clk);
        rd(OFS_STATUS, 32'h000000C0, 32'h00000040, "bus on");
        queue(16'h0000, RES_SUCCESS);
        queue(16'h0000, RES_BUF_FULL);
        cshi_ctrl_model_inst.push(29'h00000456, 6'h00, 64'h0);
        cmd(CMD_RESET, RES_SUCCESS);
        chk(64'(n_restart), 64'h0000000000000001, "restart pulse");
        repeat (6) @(posedge clk);
        rd(OFS_OVERFLOW, 32'h00000003, 32'h00000000, "ovf after reset");
        rd(OFS_STATUS, 32'h000000C7, 32'h00000004, "status after reset");
        cmd(CMD_FETCH, RES_BUF_EMPTY);
        queue(16'h0005, RES_SUCCESS);
        wait_done();
        chk(64'(n_start), 64'h0000000000000004, "start pulses");
        conclude();
    end
endmodule
